// ===== ssec_map.vh
// Purpose: shared constants for the slave state error checker
// Assumes: 40 MHz core clock, APB register access with 12-bit byte addresses
// Notes: state codes sit in the low nibble of the request field
// What this block does
// R1: requested states coded 0x01 reset, 0x02 config, 0x03 fw update, 0x04 inputs-only, 0x08 run.
// R2: bit 4 of the request field acknowledges an error, e.g. request 0x14.
// R3: disallowed transition returns 0x0011, state kept, error set.
// R4: undefined request code returns 0x0012, state kept, error set.
// R5: fw update unsupported: reset to fw update returns 0x0013, stays reset.
// R6: unusable firmware: reset to config returns 0x0014, stays reset.
// R7: oversized download returns 0x0002 in any state, state kept.
// R8: config to inputs-only with bad revision mapping returns 0x0004, stays config.
// R9: mailbox setup mismatch: 0x0015 toward fw update, 0x0016 from reset toward config or inputs-only.
// R10: buffer manager entries at 0x800 hold start, length and direction.
// R11: process data length/start/direction mismatch returns 0x0017, state kept.
// R12: no valid inputs in or entering run returns 0x0018, to inputs-only.
// R13: stalled toggle or outputs not valid returns 0x0019, to inputs-only.
// R14: toggle failures past limit or sync loss return 0x001A, to inputs-only.
// R15: watchdog restarted by new outputs, 100 ms, expiry returns 0x001B.
// R16: bad unit type 0x001C, output config 0x001D, input config 0x001E.
// R17: rejected watchdog setup (0x400/0x420) returns 0x001F, to config.
// R18: unspecified error returns 0x0001; 0x0000 means no error.
// R19: power cycle needed returns 0x0020, state kept, error set.
// R20: state plus error flag and last code readable, updated together.
// R21: error flag clears only on acknowledge; code stays readable until then.
`ifndef SSEC_MAP_VH
`define SSEC_MAP_VH
`define SSEC_ST_RESET   4'h1
`define SSEC_ST_CONFIG  4'h2
`define SSEC_ST_FWUPD   4'h3
`define SSEC_ST_INONLY  4'h4
`define SSEC_ST_RUN     4'h8
`define SSEC_REQ_ACK    4
`define SSEC_C_NONE     16'h0000
`define SSEC_C_UNSPEC   16'h0001
`define SSEC_C_NOMEM    16'h0002
`define SSEC_C_REV      16'h0004
`define SSEC_C_TRANS    16'h0011
`define SSEC_C_UNKNOWN  16'h0012
`define SSEC_C_NOBOOT   16'h0013
`define SSEC_C_NOFW     16'h0014
`define SSEC_C_MBXB     16'h0015
`define SSEC_C_MBX      16'h0016
`define SSEC_C_PDCFG    16'h0017
`define SSEC_C_NOIN     16'h0018
`define SSEC_C_NOOUT    16'h0019
`define SSEC_C_SYNC     16'h001A
`define SSEC_C_WDOG     16'h001B
`define SSEC_C_TYPE     16'h001C
`define SSEC_C_OCFG     16'h001D
`define SSEC_C_ICFG     16'h001E
`define SSEC_C_WDCFG    16'h001F
`define SSEC_C_COLD     16'h0020
`define SSEC_A_REQ      12'h000
`define SSEC_A_STATUS   12'h004
`define SSEC_A_CODE     12'h008
`define SSEC_A_TGLCNT   12'h00C
`define SSEC_A_WDDIV    12'h400
`define SSEC_A_WDTIME   12'h420
`define SSEC_A_BM       12'h800
`define SSEC_BM_MASK    12'hFE0
`define SSEC_BM_EN      15
`define SSEC_BM_DIR     12
`define SSEC_BM_TYPE_HI 14
`define SSEC_BM_TYPE_LO 13
`define SSEC_TY_MBX     2'h2
`define SSEC_TY_PD      2'h0
`define SSEC_DIR_OUT    1'b0
`define SSEC_DIR_IN     1'b1
`define SSEC_WD_TIME_MS 100
`define SSEC_CLK_KHZ    40000
`define SSEC_WDDIV_RST  16'h0F9F
`define SSEC_WDTIME_RST 16'h03E8
`endif

// ===== ssec_wdog.v
// Purpose: process-data watchdog counting core cycles between output updates
// Assumes: limit is nonzero while run is high
// Notes: expired is a one-cycle pulse; the count restarts by itself after it
module ssec_wdog (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_sync_b,
  // control
  input  wire        run,
  input  wire        kick,
  input  wire [31:0] limit,
  // event
  output reg         expired
);
  reg  [31:0] cnt_r;

  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt_r   <= 32'h0;
      expired <= 1'b0;
    end else if (!run || kick) begin // [R15]
      cnt_r   <= 32'h0;
      expired <= 1'b0;
    end else if (cnt_r == limit - 32'h1) begin
      cnt_r   <= 32'h0;
      expired <= 1'b1;
    end else begin
      cnt_r   <= cnt_r + 32'h1;
      expired <= 1'b0;
    end
  end
endmodule // ssec_wdog

// ===== ssec_tglmon.v
// Purpose: output toggle flag monitor with failure counter
// Assumes: new_data pulses once per received output update
// Notes: counter saturates; stalled and the counter clear while inactive, last toggle tracks the input
module ssec_tglmon #(
  parameter          CW    = 8,
  parameter [CW-1:0] LIMIT = 8'h08
) (
  // clock and reset
  input  wire          core_clk,
  input  wire          rst_sync_b,
  // inputs
  input  wire          active,
  input  wire          new_data,
  input  wire          toggle,
  // results
  output reg           stalled,
  output wire          limit_hit,
  output reg  [CW-1:0] fail_cnt
);
  reg          last_r;

  assign limit_hit = (fail_cnt > LIMIT); // [R14]

  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      last_r   <= 1'b0;
      stalled  <= 1'b0;
      fail_cnt <= {CW{1'b0}};
    end else if (!active) begin
      last_r   <= toggle;
      stalled  <= 1'b0;
      fail_cnt <= {CW{1'b0}};
    end else if (new_data) begin
      last_r <= toggle;
      if (toggle == last_r) begin // [R13]
        stalled <= 1'b1;
        if (fail_cnt != {CW{1'b1}}) begin
          fail_cnt <= fail_cnt + {{(CW-1){1'b0}}, 1'b1}; // [R14]
        end
      end else begin
        stalled <= 1'b0;
      end
    end
  end
endmodule // ssec_tglmon

// ===== ssec_top.v
// Purpose: state request checker with status code reporting for a fieldbus slave
// Assumes: application inputs are on core_clk; APB slave with one wait state
// Notes: overflow, cold start and unspecified errors win over an acknowledge in the same cycle
//
// Decided for this implementation: the APB register port.
`include "ssec_map.vh"
module ssec_top #(
  parameter [31:0] WD_CYC     = `SSEC_WD_TIME_MS * `SSEC_CLK_KHZ,
  parameter        BOOT_OK    = 1,
  parameter [7:0]  TGL_LIMIT  = 8'h08,
  parameter [11:0] MBXO_START = 12'h000,
  parameter [11:0] MBXO_LEN   = 12'h080,
  parameter [11:0] MBXI_START = 12'h080,
  parameter [11:0] MBXI_LEN   = 12'h080,
  parameter [11:0] PDO_START  = 12'h100,
  parameter [11:0] PDI_START  = 12'h180
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_b,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // application checks
  input  wire        inputs_valid,
  input  wire        output_valid_indication,
  input  wire        output_toggle_flag,
  input  wire        out_data_new,
  input  wire        sync_lost,
  input  wire        fw_image_bad,
  input  wire        mapping_rev_bad,
  input  wire        mem_overflow,
  input  wire        cold_start_req,
  input  wire        unspec_err,
  input  wire [11:0] pd_out_len,
  input  wire [11:0] pd_in_len,
  // status
  output wire [3:0]  cur_state,
  output wire        err_flag,
  output wire [15:0] status_code
);

  reg         rst_s1_r;
  reg         rst_s2_r;
  wire        rst_sync_b;
  reg  [3:0]  state_r;
  reg         err_r;
  reg  [15:0] code_r;
  reg  [4:0]  req_r;
  reg  [15:0] wd_div_r;
  reg  [15:0] wd_time_r;
  reg  [15:0] bm_r [0:7];
  reg  [3:0]  st_nxt;
  reg         err_nxt;
  reg  [15:0] code_nxt;
  reg  [31:0] rdata;
  reg         hit;
  integer     i;

  // async assert, release through two flops
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_sync_b = rst_s2_r;

  function code_ok;
    input [3:0] s;
    begin
      code_ok = (s == `SSEC_ST_RESET) || (s == `SSEC_ST_CONFIG) ||
                (s == `SSEC_ST_FWUPD) || (s == `SSEC_ST_INONLY) ||
                (s == `SSEC_ST_RUN);
    end
  endfunction

  function trans_ok;
    input [3:0] f;
    input [3:0] t;
    begin
      trans_ok = (t == `SSEC_ST_RESET) ||
                 ((f == `SSEC_ST_RESET) && (t == `SSEC_ST_CONFIG || t == `SSEC_ST_FWUPD)) ||
                 ((f == `SSEC_ST_CONFIG) && (t == `SSEC_ST_INONLY)) ||
                 ((f == `SSEC_ST_INONLY) && (t == `SSEC_ST_CONFIG || t == `SSEC_ST_RUN)) ||
                 ((f == `SSEC_ST_RUN) && (t == `SSEC_ST_CONFIG || t == `SSEC_ST_INONLY));
    end
  endfunction

  // start word, then length/direction/type/enable word
  function bm_match;
    input [15:0] sw;
    input [15:0] cw;
    input [11:0] s;
    input [11:0] l;
    input        d;
    begin
      bm_match = (sw[11:0] == s) && (cw[11:0] == l) && (cw[`SSEC_BM_DIR] == d);
    end
  endfunction

  function [1:0] bm_type;
    input [15:0] cw;
    begin
      bm_type = cw[`SSEC_BM_TYPE_HI:`SSEC_BM_TYPE_LO];
    end
  endfunction

  // apb
  wire        acc    = psel & penable;
  wire        wr_go  = acc & pready & pwrite & hit;
  wire        req_go = wr_go & (paddr == `SSEC_A_REQ);
  wire        bm_hit = ((paddr & `SSEC_BM_MASK) == `SSEC_A_BM);
  wire [3:0]  rq     = pwdata[3:0];
  wire        rq_ack = pwdata[`SSEC_REQ_ACK];

  // configuration checks
  wire mbx_ok = bm_r[1][`SSEC_BM_EN] && bm_r[3][`SSEC_BM_EN] &&
                bm_type(bm_r[1]) == `SSEC_TY_MBX && bm_type(bm_r[3]) == `SSEC_TY_MBX &&
                bm_match(bm_r[0], bm_r[1], MBXO_START, MBXO_LEN, `SSEC_DIR_OUT) &&
                bm_match(bm_r[2], bm_r[3], MBXI_START, MBXI_LEN, `SSEC_DIR_IN); // [R9]
  wire out_used = (pd_out_len != 12'h000);
  wire in_used  = (pd_in_len != 12'h000);
  wire type_bad = (bm_r[5][`SSEC_BM_EN] && bm_type(bm_r[5]) != `SSEC_TY_PD) ||
                  (bm_r[7][`SSEC_BM_EN] && bm_type(bm_r[7]) != `SSEC_TY_PD); // [R16]
  wire ocfg_bad = (bm_r[5][`SSEC_BM_EN] != out_used); // [R16]
  wire icfg_bad = (bm_r[7][`SSEC_BM_EN] != in_used); // [R16]
  wire pd_bad   = (out_used && !bm_match(bm_r[4], bm_r[5], PDO_START, pd_out_len, `SSEC_DIR_OUT)) ||
                  (in_used && !bm_match(bm_r[6], bm_r[7], PDI_START, pd_in_len, `SSEC_DIR_IN)); // [R11]
  wire [31:0] wd_lim = ({16'h0000, wd_div_r} + 32'h1) * {16'h0000, wd_time_r};
  wire wd_bad   = (wd_time_r == 16'h0000) || (wd_lim != WD_CYC); // [R17]

  // runtime monitors
  wire       in_run   = (state_r == `SSEC_ST_RUN);
  wire       in_io    = in_run || (state_r == `SSEC_ST_INONLY);
  wire       wd_exp;
  wire       tgl_stall;
  wire       tgl_lim;
  wire [7:0] tgl_cnt;

  ssec_wdog u_wdog (
    .core_clk   (core_clk),
    .rst_sync_b (rst_sync_b),
    .run        (in_io & out_used & ~wd_bad),
    .kick       (out_data_new),
    .limit      (wd_lim),
    .expired    (wd_exp)
  );

  ssec_tglmon #(
    .CW    (8),
    .LIMIT (TGL_LIMIT)
  ) u_tglmon (
    .core_clk   (core_clk),
    .rst_sync_b (rst_sync_b),
    .active     (in_run),
    .new_data   (out_data_new),
    .toggle     (output_toggle_flag),
    .stalled    (tgl_stall),
    .limit_hit  (tgl_lim),
    .fail_cnt   (tgl_cnt)
  );

  // next state, error flag and code
  always @* begin
    st_nxt   = state_r;
    err_nxt  = err_r;
    code_nxt = code_r;
    if (req_go) begin
      if (rq_ack) begin // [R2] [R21]
        err_nxt  = 1'b0;
        code_nxt = `SSEC_C_NONE; // [R18]
      end
      if (pwdata[7:5] != 3'h0 || !code_ok(rq)) begin // [R1] [R4]
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_UNKNOWN;
      end else if (rq == state_r) begin
        st_nxt = state_r;
      end else if (state_r == `SSEC_ST_RESET && rq == `SSEC_ST_INONLY && !mbx_ok) begin
        err_nxt  = 1'b1; // [R9]
        code_nxt = `SSEC_C_MBX;
      end else if (!trans_ok(state_r, rq)) begin // [R3]
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_TRANS;
      end else if (rq == `SSEC_ST_FWUPD && BOOT_OK == 0) begin // [R5]
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_NOBOOT;
      end else if (rq == `SSEC_ST_FWUPD && !mbx_ok) begin // [R9]
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_MBXB;
      end else if (state_r == `SSEC_ST_RESET && rq == `SSEC_ST_CONFIG && fw_image_bad) begin
        err_nxt  = 1'b1; // [R6]
        code_nxt = `SSEC_C_NOFW;
      end else if (state_r == `SSEC_ST_RESET && rq == `SSEC_ST_CONFIG && !mbx_ok) begin
        err_nxt  = 1'b1; // [R9]
        code_nxt = `SSEC_C_MBX;
      end else if (state_r == `SSEC_ST_CONFIG && rq == `SSEC_ST_INONLY) begin
        if (mapping_rev_bad) begin // [R8]
          err_nxt  = 1'b1;
          code_nxt = `SSEC_C_REV;
        end else if (type_bad) begin // [R16]
          st_nxt   = `SSEC_ST_INONLY;
          err_nxt  = 1'b1;
          code_nxt = `SSEC_C_TYPE;
        end else if (ocfg_bad) begin // [R16]
          st_nxt   = `SSEC_ST_INONLY;
          err_nxt  = 1'b1;
          code_nxt = `SSEC_C_OCFG;
        end else if (icfg_bad) begin // [R16]
          st_nxt   = `SSEC_ST_INONLY;
          err_nxt  = 1'b1;
          code_nxt = `SSEC_C_ICFG;
        end else if (pd_bad) begin // [R11]
          err_nxt  = 1'b1;
          code_nxt = `SSEC_C_PDCFG;
        end else if (out_used && wd_bad) begin // [R17]
          err_nxt  = 1'b1;
          code_nxt = `SSEC_C_WDCFG;
        end else begin
          st_nxt = rq;
        end
      end else if (state_r == `SSEC_ST_INONLY && rq == `SSEC_ST_RUN) begin
        if (pd_bad) begin // [R11]
          err_nxt  = 1'b1;
          code_nxt = `SSEC_C_PDCFG;
        end else if (!inputs_valid) begin // [R12]
          err_nxt  = 1'b1;
          code_nxt = `SSEC_C_NOIN;
        end else if (!output_valid_indication) begin // [R13]
          err_nxt  = 1'b1;
          code_nxt = `SSEC_C_NOOUT;
        end else if (sync_lost) begin // [R14]
          err_nxt  = 1'b1;
          code_nxt = `SSEC_C_SYNC;
        end else begin
          st_nxt = rq;
        end
      end else begin
        st_nxt = rq;
      end
    end
    // hardware events are applied last so they beat an acknowledge and hold the state
    if (mem_overflow) begin // [R7]
      st_nxt   = state_r;
      err_nxt  = 1'b1;
      code_nxt = `SSEC_C_NOMEM;
    end else if (cold_start_req) begin // [R19]
      st_nxt   = state_r;
      err_nxt  = 1'b1;
      code_nxt = `SSEC_C_COLD;
    end else if (unspec_err) begin // [R18]
      st_nxt   = state_r;
      err_nxt  = 1'b1;
      code_nxt = `SSEC_C_UNSPEC;
    end else if (!err_nxt && in_io && !req_go) begin
      // runtime faults raise once, then wait for an acknowledge
      if (type_bad) begin // [R16]
        st_nxt   = `SSEC_ST_INONLY;
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_TYPE;
      end else if (ocfg_bad) begin // [R16]
        st_nxt   = `SSEC_ST_INONLY;
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_OCFG;
      end else if (icfg_bad) begin // [R16]
        st_nxt   = `SSEC_ST_INONLY;
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_ICFG;
      end else if (wd_exp) begin // [R15]
        st_nxt   = `SSEC_ST_INONLY;
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_WDOG;
      end else if (in_run && !inputs_valid) begin // [R12]
        st_nxt   = `SSEC_ST_INONLY;
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_NOIN;
      end else if (in_run && (!output_valid_indication || tgl_stall)) begin // [R13]
        st_nxt   = `SSEC_ST_INONLY;
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_NOOUT;
      end else if (in_run && (tgl_lim || sync_lost)) begin // [R14]
        st_nxt   = `SSEC_ST_INONLY;
        err_nxt  = 1'b1;
        code_nxt = `SSEC_C_SYNC;
      end
    end
  end

  // state, flag and code move together
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_r <= `SSEC_ST_RESET;
      err_r   <= 1'b0;
      code_r  <= `SSEC_C_NONE;
    end else begin
      state_r <= st_nxt; // [R20]
      err_r   <= err_nxt;
      code_r  <= code_nxt;
    end
  end

  // register writes
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      req_r     <= 5'h00;
      wd_div_r  <= `SSEC_WDDIV_RST;
      wd_time_r <= `SSEC_WDTIME_RST;
      for (i = 0; i < 8; i = i + 1) begin
        bm_r[i] <= 16'h0000;
      end
    end else if (wr_go) begin
      if (paddr == `SSEC_A_REQ) begin
        req_r <= pwdata[4:0];
      end
      if (paddr == `SSEC_A_WDDIV) begin
        wd_div_r <= pwdata[15:0]; // [R17]
      end
      if (paddr == `SSEC_A_WDTIME) begin
        wd_time_r <= pwdata[15:0]; // [R17]
      end
      if (bm_hit) begin
        bm_r[paddr[4:2]] <= pwdata[15:0]; // [R10]
      end
    end
  end

  // read decode
  always @* begin
    rdata = 32'h0000_0000;
    hit   = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (bm_hit) begin
      rdata = {16'h0000, bm_r[paddr[4:2]]};
    end else begin
      case (paddr)
        `SSEC_A_REQ:    rdata = {27'h0, req_r};
        `SSEC_A_STATUS: rdata = {27'h0, err_r, state_r}; // [R20]
        `SSEC_A_CODE:   rdata = {16'h0000, code_r}; // [R20]
        `SSEC_A_TGLCNT: rdata = {24'h0, tgl_cnt};
        `SSEC_A_WDDIV:  rdata = {16'h0000, wd_div_r};
        `SSEC_A_WDTIME: rdata = {16'h0000, wd_time_r};
        default:        hit   = 1'b0;
      endcase
    end
  end

  // one wait state so read data comes from a flop
  always @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (acc && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~hit;
      prdata  <= (pwrite || !hit) ? 32'h0000_0000 : rdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  assign cur_state   = state_r;
  assign err_flag    = err_r;
  assign status_code = code_r;

endmodule // ssec_top

// ===== ssec_checker.sv
// Purpose: port-level assertions for the state request checker
// Assumes: single core_clk domain, rst_b low resets everything
// Notes: attached to ssec_top by the bind at the foot of this file
module ssec_checker (
  // clock and reset
  input logic        core_clk,
  input logic        rst_b,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // events
  input logic        mem_overflow,
  input logic        cold_start_req,
  input logic        unspec_err,
  // status
  input logic [3:0]  cur_state,
  input logic        err_flag,
  input logic [15:0] status_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr0;
  logic ev;
  assign wr0 = psel & penable & pready & pwrite & (paddr == 12'h000);
  assign ev = mem_overflow | cold_start_req | unspec_err;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb answer not after exactly one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr without pready or with read data");
  a_state_legal: assert property (cur_state inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8})
    else $error("state code outside the defined set");
  a_flag_code: assert property (err_flag == (status_code != 16'h0000))
    else $error("error flag and status code disagree");
  a_ack_clears: assert property ($fell(err_flag) |-> $past(wr0 && pwdata[4]))
    else $error("error flag cleared without acknowledge");
  a_unknown_req: assert property (wr0 && pwdata[7:5] != 3'h0 && !ev |=>
    status_code == 16'h0012 && $stable(cur_state))
    else $error("undefined request not refused");
  a_mem_event: assert property (mem_overflow |=>
    status_code == 16'h0002 && err_flag && $stable(cur_state))
    else $error("memory overflow not reported");
  a_runtime_drop: assert property ($rose(err_flag) && !$past(wr0) && !$past(ev) |->
    cur_state == 4'h4)
    else $error("runtime fault did not fall to inputs only");
  a_state_cause: assert property ($changed(cur_state) |-> $past(wr0) ||
    (cur_state == 4'h4 && err_flag))
    else $error("state changed without request or fault");
endmodule // ssec_checker

bind ssec_top ssec_checker u_ssec_checker (
  .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_overflow(mem_overflow), .cold_start_req(cold_start_req), .unspec_err(unspec_err),
  .cur_state(cur_state), .err_flag(err_flag), .status_code(status_code)
);

// ===== ssec_app_model.sv
// Purpose: slave application model producing output updates
// Assumes: one update every 8 core cycles while enabled
// Notes: stall keeps the toggle flag frozen so the monitor sees a stuck toggle
module ssec_app_model (
  // clock
  input  logic core_clk,
  // bench control
  input  logic en,
  input  logic stall,
  // toward the block
  output logic out_data_new,
  output logic output_toggle_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_r = 3'h0;
  initial out_data_new = 1'b0;
  initial output_toggle_flag = 1'b0;
  always @(posedge core_clk) begin
    cnt_r <= cnt_r + 3'h1;
    out_data_new <= en && (cnt_r == 3'h7);
    if (en && cnt_r == 3'h7 && !stall) output_toggle_flag <= !output_toggle_flag;
  end
endmodule // ssec_app_model

// ===== slave_state_error_checker_tb_top.sv
// Purpose: self-checking bench for the state request checker
// Assumes: watchdog shortened to 40 cycles, firmware update state absent
// Notes: random request codes, defined or undefined, come from a fixed-seed xorshift
module slave_state_error_checker_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, pd_out_len, pd_in_len;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        er, inputs_valid, out_valid, tgl, odn, sync_lost, fw_image_bad;
  logic        mapping_rev_bad, mem_overflow, cold_start_req, unspec_err, en, stall;
  logic [3:0]  cur_state;
  logic        err_flag;
  logic [15:0] status_code;
  logic [7:0]  v;
  logic [19:0] x;
  logic [15:0] bmd [8] = '{16'h0000, 16'hC080, 16'h0080, 16'hD080,
                           16'h0100, 16'h8010, 16'h0180, 16'h9010};
  int          fail_count = 0;
  int          checked = 0;

  ssec_top #(.WD_CYC(32'h00000028), .BOOT_OK(0)) u_ssec_top (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inputs_valid(inputs_valid), .output_valid_indication(out_valid),
    .output_toggle_flag(tgl), .out_data_new(odn), .sync_lost(sync_lost),
    .fw_image_bad(fw_image_bad), .mapping_rev_bad(mapping_rev_bad),
    .mem_overflow(mem_overflow), .cold_start_req(cold_start_req), .unspec_err(unspec_err),
    .pd_out_len(pd_out_len), .pd_in_len(pd_in_len), .cur_state(cur_state),
    .err_flag(err_flag), .status_code(status_code));
  ssec_app_model u_ssec_app_model (.core_clk(core_clk), .en(en), .stall(stall),
    .out_data_new(odn), .output_toggle_flag(tgl));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // expected {state, code} for a request made from reset with a good mailbox
  function automatic logic [19:0] exp_req(input logic [7:0] r);
    if (r[7:5] != 3'h0) return {4'h1, 16'h0012};
    case (r[3:0])
      4'h1: return {4'h1, 16'h0000};
      4'h2: return {4'h2, 16'h0000};
      4'h3: return {4'h1, 16'h0013};
      4'h4, 4'h8: return {4'h1, 16'h0011};
      default: return {4'h1, 16'h0012};
    endcase
  endfunction

  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    chk(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic req(input logic [7:0] r);
    apb(1'b1, 12'h000, {24'h0, r});
  endtask

  // status and code seen on the ports and through both readable fields
  task automatic st(input logic [3:0] s, input logic e, input logic [15:0] c);
    logic [31:0] a;
    apb(1'b0, 12'h004, 32'h0);
    a = rd;
    apb(1'b0, 12'h008, 32'h0);
    chk({a, rd, cur_state, err_flag, status_code}, {27'h0, e, s, 16'h0, c, s, e, c});
  endtask

  task final_report;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #200us;
    fail_count++;
    final_report;
  end

  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {sync_lost, fw_image_bad, mapping_rev_bad, mem_overflow, cold_start_req} = '0;
    {unspec_err, en, stall} = '0;
    {inputs_valid, out_valid} = 2'h3;
    pd_out_len = 12'h010;
    pd_in_len = 12'h010;
    seed = 32'h00008D05;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    st(4'h1, 1'b0, 16'h0000);
    apb(1'b0, 12'h400, 32'h0);
    chk(rd, 32'h00000F9F);
    apb(1'b0, 12'h420, 32'h0);
    chk(rd, 32'h000003E8);
    apb(1'b0, 12'h300, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    req(8'h08);
    st(4'h1, 1'b1, 16'h0011);
    req(8'h01);
    st(4'h1, 1'b1, 16'h0011);
    req(8'h11);
    st(4'h1, 1'b0, 16'h0000);
    req(8'h03);
    st(4'h1, 1'b1, 16'h0013);
    req(8'h02);
    st(4'h1, 1'b1, 16'h0016);
    for (int i = 0; i < 8; i++) apb(1'b1, 12'h800 + 12'(4 * i), {16'h0, bmd[i]});
    apb(1'b0, 12'h814, 32'h0);
    chk(rd, 32'h00008010);
    fw_image_bad <= 1'b1;
    req(8'h12);
    st(4'h1, 1'b1, 16'h0014);
    fw_image_bad <= 1'b0;
    req(8'h11);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      v = seed[7:0];
      x = exp_req(v);
      req(v);
      st(x[19:16], x[15:0] != 16'h0, x[15:0]);
      req(x[19:16] == 4'h2 ? 8'h01 : 8'h11);
    end
    req(8'h02);
    mapping_rev_bad <= 1'b1;
    req(8'h04);
    st(4'h2, 1'b1, 16'h0004);
    mapping_rev_bad <= 1'b0;
    pd_in_len <= 12'h020;
    req(8'h14);
    st(4'h2, 1'b1, 16'h0017);
    pd_in_len <= 12'h010;
    req(8'h14);
    st(4'h2, 1'b1, 16'h001F);
    apb(1'b1, 12'h400, 32'h3);
    apb(1'b1, 12'h420, 32'hA);
    pd_out_len <= 12'h000;
    req(8'h14);
    st(4'h4, 1'b1, 16'h001D);
    pd_out_len <= 12'h010;
    req(8'h12);
    en <= 1'b1;
    req(8'h04);
    st(4'h4, 1'b0, 16'h0000);
    pd_in_len <= 12'h020;
    req(8'h08);
    st(4'h4, 1'b1, 16'h0017);
    pd_in_len <= 12'h010;
    inputs_valid <= 1'b0;
    req(8'h08);
    st(4'h4, 1'b1, 16'h0018);
    inputs_valid <= 1'b1;
    req(8'h18);
    st(4'h8, 1'b0, 16'h0000);
    stall <= 1'b1;
    repeat (20) @(posedge core_clk);
    st(4'h4, 1'b1, 16'h0019);
    stall <= 1'b0;
    req(8'h18);
    out_valid <= 1'b0;
    @(posedge core_clk);
    out_valid <= 1'b1;
    st(4'h4, 1'b1, 16'h0019);
    req(8'h18);
    sync_lost <= 1'b1;
    repeat (3) @(posedge core_clk);
    st(4'h4, 1'b1, 16'h001A);
    sync_lost <= 1'b0;
    req(8'h18);
    // last kick may lie up to 8 cycles back, so the early look stays well short of 40
    en <= 1'b0;
    repeat (25) @(posedge core_clk);
    chk(cur_state, 4'h8);
    repeat (30) @(posedge core_clk);
    st(4'h4, 1'b1, 16'h001B);
    mem_overflow <= 1'b1;
    @(posedge core_clk);
    mem_overflow <= 1'b0;
    st(4'h4, 1'b1, 16'h0002);
    cold_start_req <= 1'b1;
    @(posedge core_clk);
    cold_start_req <= 1'b0;
    st(4'h4, 1'b1, 16'h0020);
    unspec_err <= 1'b1;
    @(posedge core_clk);
    unspec_err <= 1'b0;
    st(4'h4, 1'b1, 16'h0001);
    apb(1'b1, 12'h004, 32'hFF);
    st(4'h4, 1'b1, 16'h0001);
    final_report;
  end
endmodule // slave_state_error_checker_tb_top
